// File: rtl/tbc_consts.vh
// Purpose: constants for the tag block command handler
// Assumes: included once per file by bare name
// Notes: offsets are AHB byte addresses
// Function
// - Block addresses are one byte, 0 to 255.
// - Block count field is blocks wanted minus one.
// - Multi-block read returns consecutive blocks from the first block number.
// - Multi-block read: code 010010, optional UID, first block, count, CRC.
// - Basic variant accepts multi-block reads only in ready-state addressing; the code also accepts UID-addressed reads in any tag state.
// - Read reply: zero error flag, 32 bits per block, optional CRC.
// - Anticollision read carries mask length, mask, first block, count.
// - Any error in anticollision read means no reply at all.
// - Anticollision reply: unmasked UID bits dual-pattern, then Manchester rest.
// - Good write stores 32 data bits in the block and reports success.
// - Write: code 010100, optional UID, block number, 32 data bits, CRC.
// - Good write, lock or select reply is just a zero error flag.
// - Good lock permanently blocks further writes to that block.
// - Blocks 00h-17h, FEh and FFh lock individually.
// - Largest variant: lock of any block 18h-36h locks the whole range.
// - With password protection, lock needs a prior successful login.
// - Lock: code 010110, optional UID, block number, optional CRC.
// - Select: code 011000, mandatory 48-bit UID, optional CRC.
// - Matching select UID enters selected state and replies.
// - Mismatching select in ready or quiet keeps state, stays silent.
// - Mismatching select in selected state goes quiet, no reply.
// - Error reply is error flag 1 plus code 111, optional CRC.
// - CRC appended to reply only when reply checksum flag is 1.
// - Single slot flag 0 means sixteen slots, 1 means one slot.
// - Flag pairs 00 ready tags, 10 UID match, 01 selected, 11 reserved.
`ifndef TBC_CONSTS_VH
`define TBC_CONSTS_VH
`define TBC_CMD_READ_MULTI 6'h12
`define TBC_CMD_WRITE 6'h14
`define TBC_CMD_LOCK 6'h16
`define TBC_CMD_SELECT 6'h18
`define TBC_FLAG_ADDR 4
`define TBC_FLAG_CHOSEN 3
`define TBC_FLAG_CRC 2
`define TBC_FLAG_AC 1
`define TBC_FLAG_EXT 0
`define TBC_ERR_CODE 3'h7
`define TBC_UID_BITS 6'd48
`define TBC_LAST_USER 8'h36
`define TBC_RANGE_LO 8'h18
`define TBC_IDX_FE 6'h37
`define TBC_IDX_FF 6'h38
`define TBC_IDX_NONE 6'h3F
`define TBC_NUM_BLK 57
`define TBC_OFF_CTRL 32'h0000_0000
`define TBC_OFF_UID_LO 32'h0000_0004
`define TBC_OFF_UID_HI 32'h0000_0008
`define TBC_OFF_STATUS 32'h0000_000C
`define TBC_OFF_COUNT 32'h0000_0010
`define TBC_CTRL_PWD 0
`define TBC_CTRL_LOGIN 1
`define TBC_CTRL_RANGE 2
`define TBC_CTRL_BASIC 3
`define TBC_CTRL_RST 4'h0
`define TBC_UID_RST 48'h0000_1234_5678
`define TBC_KIND_UID 2'h0
`define TBC_KIND_FLAG 2'h1
`define TBC_KIND_WORD 2'h2
`define TBC_KIND_END 2'h3
`endif

// File: rtl/tbc_command_handler.v
// Purpose: decode reader requests, keep tag state and memory, build replies
// Assumes: requests arrive decoded with CRC already checked by the front end
// Notes: one clock, registers on AHB-Lite with zero wait states
`timescale 1ns/1ps
`include "tbc_consts.vh"
module tbc_command_handler (
  // AHB-Lite slave
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // Decoded request
  input wire req_valid,
  output wire req_ready,
  input wire [4:0] req_flags,
  input wire [5:0] req_cmd,
  input wire [47:0] req_uid,
  input wire [5:0] req_mask_len,
  input wire [47:0] req_mask,
  input wire [7:0] req_block,
  input wire [7:0] req_count,
  input wire [31:0] req_data,
  input wire req_error,
  input wire slot_pulse,
  // Reply stream
  output wire rsp_valid,
  input wire rsp_ready,
  output reg [1:0] rsp_kind,
  output reg [47:0] rsp_data,
  output reg [5:0] rsp_bits,
  output reg rsp_dual
);

  localparam [5:0] ST_IDLE = 6'b000001;
  localparam [5:0] ST_SLOT = 6'b000010;
  localparam [5:0] ST_UID = 6'b000100;
  localparam [5:0] ST_FLAG = 6'b001000;
  localparam [5:0] ST_DATA = 6'b010000;
  localparam [5:0] ST_END = 6'b100000;
  localparam [2:0] TAG_READY = 3'b001;
  localparam [2:0] TAG_SEL = 3'b010;
  localparam [2:0] TAG_QUIET = 3'b100;

  function [5:0] blk_idx;
    input [7:0] a;
    begin
      if (a <= `TBC_LAST_USER) begin
        blk_idx = a[5:0];
      end else if (a == 8'hFE) begin
        blk_idx = `TBC_IDX_FE;
      end else if (a == 8'hFF) begin
        blk_idx = `TBC_IDX_FF;
      end else begin
        blk_idx = `TBC_IDX_NONE;
      end
    end
  endfunction

  function in_range;
    input [7:0] a;
    begin
      in_range = (a >= `TBC_RANGE_LO) && (a <= `TBC_LAST_USER);
    end
  endfunction

  // Reply field builders
  function [47:0] flag_field;
    input err;
    begin
      if (err) begin
        flag_field = {44'h000_0000_0000, 1'b1, `TBC_ERR_CODE};
      end else begin
        flag_field = 48'h0000_0000_0000;
      end
    end
  endfunction

  function [5:0] flag_len;
    input err;
    begin
      if (err) begin
        flag_len = 6'd4;
      end else begin
        flag_len = 6'd1;
      end
    end
  endfunction

  function [47:0] end_field;
    input crc;
    begin
      end_field = {47'h0000_0000_0000, crc};
    end
  endfunction

  reg [31:0] mem [0:`TBC_NUM_BLK-1];
  reg [`TBC_NUM_BLK-1:0] locked;
  reg [3:0] ctrl;
  reg [47:0] own_uid;
  reg [2:0] tag_state;
  reg [5:0] state;
  reg [7:0] q_block;
  reg [7:0] q_left;
  reg q_err;
  reg q_read;
  reg q_crc;
  reg q_ac;
  reg [3:0] slot_wait;
  reg [15:0] req_total;
  reg last_err;
  reg ap_wr;
  reg [31:0] ap_addr;
  integer i;

  function [47:0] word_field;
    input [7:0] a;
    begin
      word_field = {16'h0000, mem[blk_idx(a)]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Request evaluation
  wire f_adr = req_flags[`TBC_FLAG_ADDR];
  wire f_sel = req_flags[`TBC_FLAG_CHOSEN];
  wire f_crc = req_flags[`TBC_FLAG_CRC];
  wire f_ac = req_flags[`TBC_FLAG_AC];
  wire f_ext = req_flags[`TBC_FLAG_EXT];
  wire uid_match = (req_uid == own_uid);
  wire [47:0] low_mask = ~({48{1'b1}} << req_mask_len);
  wire mask_ok = (req_mask_len <= `TBC_UID_BITS) &&
                 (((req_mask ^ own_uid) & low_mask) == 48'h0000_0000_0000);
  wire [47:0] uid_rest = own_uid >> req_mask_len;
  wire [8:0] last_blk = {1'b0, req_block} + {1'b0, req_count};
  wire read_ok = (last_blk <= {1'b0, `TBC_LAST_USER}) ||
                 (req_block >= 8'hFE && last_blk <= 9'h0FF);
  wire [5:0] w_idx = blk_idx(req_block);
  wire idx_ok = (w_idx != `TBC_IDX_NONE);
  wire is_read = (req_cmd == `TBC_CMD_READ_MULTI);
  wire is_write = (req_cmd == `TBC_CMD_WRITE);
  wire is_lock = (req_cmd == `TBC_CMD_LOCK);
  wire is_sel = (req_cmd == `TBC_CMD_SELECT);
  wire range_lock = ctrl[`TBC_CTRL_RANGE] && in_range(req_block);

  reg addressed;
  reg respond;
  reg error;
  always @* begin
    addressed = 1'b0;
    case ({f_adr, f_sel})
      2'b00: addressed = (tag_state == TAG_READY);
      2'b10: addressed = uid_match;
      2'b01: addressed = (tag_state == TAG_SEL) && !ctrl[`TBC_CTRL_BASIC];
      default: addressed = 1'b0;
    endcase
    respond = 1'b0;
    error = req_error;
    if (f_ext) begin
      respond = 1'b0;
    end else if (f_ac) begin
      respond = is_read && !ctrl[`TBC_CTRL_BASIC] && (tag_state == TAG_READY) &&
                mask_ok && read_ok && !req_error;
      error = 1'b0;
    end else if (is_sel) begin
      respond = f_adr && !f_sel && (uid_match || req_error);
    end else if (is_read) begin
      respond = addressed;
      error = req_error || !read_ok;
    end else if (is_write || is_lock) begin
      respond = addressed;
      error = req_error || !idx_ok || locked[w_idx];
      if (is_lock && ctrl[`TBC_CTRL_PWD] && !ctrl[`TBC_CTRL_LOGIN]) begin
        error = 1'b1;
      end
    end
  end

  assign req_ready = (state == ST_IDLE);
  wire accept = req_valid && req_ready;
  assign rsp_valid = (state == ST_UID) || (state == ST_FLAG) ||
                     (state == ST_DATA) || (state == ST_END);

  ////////////////////////////////////////////////////////////////////
  // Tag state, memory and locks
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tag_state <= TAG_READY;
      locked <= {`TBC_NUM_BLK{1'b0}};
      req_total <= 16'h0000;
      last_err <= 1'b0;
    end else if (accept) begin
      req_total <= req_total + 16'h0001;
      last_err <= respond && error;
      if (is_sel && !f_ac && !f_ext && !req_error) begin
        if (uid_match) begin
          tag_state <= TAG_SEL;
        end else if (tag_state == TAG_SEL) begin
          tag_state <= TAG_QUIET;
        end
      end
      if (respond && !error && !f_ac && is_lock) begin
        if (range_lock) begin
          for (i = 24; i <= 54; i = i + 1) begin
            locked[i] <= 1'b1;
          end
        end else begin
          locked[w_idx] <= 1'b1;
        end
      end
    end
  end

  always @(posedge hclk) begin
    if (accept && respond && !error && !f_ac && is_write) begin
      mem[w_idx] <= req_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Reply sequencer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      q_block <= 8'h00;
      q_left <= 8'h00;
      q_err <= 1'b0;
      q_read <= 1'b0;
      q_crc <= 1'b0;
      q_ac <= 1'b0;
      slot_wait <= 4'h0;
      rsp_kind <= `TBC_KIND_FLAG;
      rsp_data <= 48'h0000_0000_0000;
      rsp_bits <= 6'h00;
      rsp_dual <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (accept && respond) begin
            q_block <= req_block;
            q_left <= req_count;
            q_err <= error;
            q_read <= is_read && !f_ac;
            q_crc <= f_crc;
            q_ac <= f_ac;
            if (f_ac) begin
              rsp_kind <= `TBC_KIND_UID;
              rsp_data <= uid_rest;
              rsp_bits <= `TBC_UID_BITS - req_mask_len;
              rsp_dual <= 1'b1;
              q_read <= 1'b1;
              slot_wait <= f_adr ? 4'h0 : uid_rest[3:0];
              state <= ST_SLOT;
            end else begin
              rsp_kind <= `TBC_KIND_FLAG;
              rsp_data <= flag_field(error);
              rsp_bits <= flag_len(error);
              rsp_dual <= 1'b0;
              state <= ST_FLAG;
            end
          end
        end
        ST_SLOT: begin
          if (slot_wait == 4'h0) begin
            state <= ST_UID;
          end else if (slot_pulse) begin
            slot_wait <= slot_wait - 4'h1;
          end
        end
        ST_UID: begin
          if (rsp_ready) begin
            rsp_kind <= `TBC_KIND_FLAG;
            rsp_data <= flag_field(1'b0);
            rsp_bits <= flag_len(1'b0);
            rsp_dual <= 1'b0;
            state <= ST_FLAG;
          end
        end
        ST_FLAG: begin
          if (rsp_ready) begin
            if (q_read && !q_err) begin
              rsp_kind <= `TBC_KIND_WORD;
              rsp_data <= word_field(q_block);
              rsp_bits <= 6'd32;
              state <= ST_DATA;
            end else begin
              rsp_kind <= `TBC_KIND_END;
              rsp_data <= end_field(q_crc);
              rsp_bits <= 6'd0;
              state <= ST_END;
            end
          end
        end
        ST_DATA: begin
          if (rsp_ready) begin
            if (q_left == 8'h00) begin
              rsp_kind <= `TBC_KIND_END;
              rsp_data <= end_field(q_crc);
              rsp_bits <= 6'd0;
              state <= ST_END;
            end else begin
              q_block <= q_block + 8'h01;
              q_left <= q_left - 8'h01;
              rsp_data <= word_field(q_block + 8'h01);
            end
          end
        end
        ST_END: begin
          if (rsp_ready) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // AHB-Lite register slave
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  wire ap_take = hsel && hready && htrans[1];
  // Status: ac flag, last error, sequencer state, tag state
  wire [31:0] status_word = {20'h0_0000, q_ac, last_err, state, tag_state, 1'b0};
  wire [31:0] count_word = {16'h0000, req_total};

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr <= 1'b0;
      ap_addr <= 32'h0000_0000;
      ctrl <= `TBC_CTRL_RST;
      own_uid <= `TBC_UID_RST;
      hrdata <= 32'h0000_0000;
    end else begin
      ap_wr <= ap_take && hwrite;
      if (ap_take) begin
        ap_addr <= haddr;
      end
      if (ap_wr) begin
        if (ap_addr == `TBC_OFF_CTRL) begin
          ctrl <= hwdata[3:0];
        end else if (ap_addr == `TBC_OFF_UID_LO) begin
          own_uid[31:0] <= hwdata;
        end else if (ap_addr == `TBC_OFF_UID_HI) begin
          own_uid[47:32] <= hwdata[15:0];
        end
      end
      if (ap_take && !hwrite) begin
        if (haddr == `TBC_OFF_CTRL) begin
          hrdata <= {28'h000_0000, ctrl};
        end else if (haddr == `TBC_OFF_UID_LO) begin
          hrdata <= own_uid[31:0];
        end else if (haddr == `TBC_OFF_UID_HI) begin
          hrdata <= {16'h0000, own_uid[47:32]};
        end else if (haddr == `TBC_OFF_STATUS) begin
          hrdata <= status_word;
        end else if (haddr == `TBC_OFF_COUNT) begin
          hrdata <= count_word;
        end else begin
          hrdata <= 32'h0000_0000;
        end
      end
    end
  end

endmodule

// File: bench/tbc_checker.sv
// Purpose: port checks on the command handler reply stream
// Assumes: own UID stays at its reset value
// Notes: bound to the handler below
`timescale 1ns/1ps
`include "tbc_consts.vh"
module tbc_checker (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Request
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [4:0] req_flags,
  input wire logic [5:0] req_cmd,
  input wire logic [47:0] req_uid,
  input wire logic [5:0] req_mask_len,
  input wire logic [7:0] req_count,
  input wire logic req_error,
  // Reply
  input wire logic rsp_valid,
  input wire logic rsp_ready,
  input wire logic [1:0] rsp_kind,
  input wire logic [47:0] rsp_data,
  input wire logic [5:0] rsp_bits,
  input wire logic rsp_dual
);
  logic crc_q, ac_q, first_q, err_q, rd_q;
  logic [5:0] len_q;
  logic [7:0] cnt_q;
  logic [8:0] words;
  wire acc = req_valid && req_ready;
  wire take = rsp_valid && rsp_ready;
  // Snapshot of the accepted request
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {crc_q, ac_q, first_q, err_q, rd_q, len_q, cnt_q, words} <= '0;
    end else if (acc) begin
      crc_q <= req_flags[`TBC_FLAG_CRC];
      ac_q <= req_flags[`TBC_FLAG_AC];
      rd_q <= req_cmd == `TBC_CMD_READ_MULTI;
      len_q <= req_mask_len;
      cnt_q <= req_count;
      first_q <= 1'b1;
      err_q <= 1'b0;
      words <= 9'h000;
    end else if (take) begin
      first_q <= 1'b0;
      if (rsp_kind == `TBC_KIND_FLAG && rsp_bits != 6'd1) err_q <= 1'b1;
      if (rsp_kind == `TBC_KIND_WORD) words <= words + 9'h001;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_acc_sel;
    acc && req_cmd == `TBC_CMD_SELECT && !req_error;
  endsequence
  sequence s_quiet;
    !rsp_valid [*3];
  endsequence
  a_sel_hit_reply: assert property (s_acc_sel ##0 req_uid == `TBC_UID_RST |=>
    rsp_valid && rsp_kind == `TBC_KIND_FLAG && rsp_bits == 6'd1 && !rsp_data[0])
    else $error("select hit gave no success flag");
  a_sel_miss_quiet: assert property (s_acc_sel ##0 req_uid != `TBC_UID_RST |=> s_quiet)
    else $error("select miss replied");
  a_ac_err_silent: assert property (acc && req_flags[`TBC_FLAG_AC] && req_error |=> s_quiet)
    else $error("faulty anticollision read replied");
  a_err_flag_form: assert property (rsp_valid && rsp_kind == `TBC_KIND_FLAG
    && rsp_bits != 6'd1 |-> rsp_bits == 6'd4 && rsp_data[3:0] == 4'hF)
    else $error("bad error flag field");
  a_ok_flag_form: assert property (rsp_valid && rsp_kind == `TBC_KIND_FLAG
    && rsp_bits == 6'd1 |-> !rsp_data[0])
    else $error("success flag not zero");
  a_reply_stands: assert property (rsp_valid && !rsp_ready |=> rsp_valid
    && $stable(rsp_kind) && $stable(rsp_data) && $stable(rsp_bits))
    else $error("reply field changed while stalled");
  a_crc_marker: assert property (rsp_valid && rsp_kind == `TBC_KIND_END
    |-> rsp_data[0] == crc_q)
    else $error("checksum marker differs from request");
  a_ac_uid_first: assert property (rsp_valid && first_q && ac_q
    |-> rsp_kind == `TBC_KIND_UID && rsp_dual && rsp_bits == 6'd48 - len_q)
    else $error("anticollision reply not led by UID segment");
  a_manch_rest: assert property (rsp_valid && rsp_kind != `TBC_KIND_UID |-> !rsp_dual)
    else $error("non UID field dual coded");
  a_word_count: assert property (rsp_valid && rsp_kind == `TBC_KIND_END && rd_q
    && !err_q |-> words == {1'b0, cnt_q} + 9'd1)
    else $error("wrong number of data words");
endmodule
bind tbc_command_handler tbc_checker u_chk (.hclk(hclk), .hresetn(hresetn),
  .req_valid(req_valid), .req_ready(req_ready), .req_flags(req_flags), .req_cmd(req_cmd),
  .req_uid(req_uid), .req_mask_len(req_mask_len), .req_count(req_count),
  .req_error(req_error), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
  .rsp_kind(rsp_kind), .rsp_data(rsp_data), .rsp_bits(rsp_bits), .rsp_dual(rsp_dual));

// File: bench/tbc_reader_model.sv
// Purpose: reader side model, sends requests and collects reply fields
// Assumes: anticollision mask is always the tag's own UID
// Notes: slow makes the reply side stall three cycles in four
`timescale 1ns/1ps
module tbc_reader (
  // Clock
  input wire logic clk,
  // Requests
  input wire logic req_ready,
  output logic req_valid,
  output wire logic [4:0] req_flags,
  output wire logic [5:0] req_cmd,
  output wire logic [47:0] req_uid,
  output wire logic [5:0] req_mask_len,
  output wire logic [47:0] req_mask,
  output wire logic [7:0] req_block,
  output wire logic [7:0] req_count,
  output wire logic [31:0] req_data,
  output wire logic req_error,
  output logic slot_pulse,
  // Replies
  input wire logic rsp_valid,
  output logic rsp_ready,
  input wire logic [1:0] rsp_kind,
  input wire logic [47:0] rsp_data,
  input wire logic [5:0] rsp_bits,
  input wire logic rsp_dual
);
  logic [56:0] q[$];
  logic slow = 1'b0;
  logic [3:0] tick = 4'h0;
  logic [161:0] body = '0;
  assign {req_flags, req_cmd, req_uid, req_mask_len, req_mask, req_block, req_count,
    req_data, req_error} = body;
  initial begin
    req_valid = 1'b0;
    slot_pulse = 1'b0;
    rsp_ready = 1'b1;
  end
  always @(posedge clk) begin
    tick <= tick + 4'h1;
    slot_pulse <= tick == 4'hF;
    rsp_ready <= !slow || tick[1:0] == 2'b00;
    if (rsp_valid && rsp_ready) q.push_back({rsp_kind, rsp_dual, rsp_bits, rsp_data});
  end
  task automatic send(input logic [4:0] f, input logic [5:0] c, input logic [47:0] u,
    input logic [5:0] ml, input logic [7:0] b, n, input logic [31:0] d, input logic e);
    int i;
    @(posedge clk);
    req_valid <= 1'b1;
    body <= {f, c, u, ml, u, b, n, d, e};
    @(posedge clk);
    while (!req_ready) @(posedge clk);
    req_valid <= 1'b0;
    body <= ~body;
    i = 0;
    while (i < 3) begin
      @(posedge clk);
      i = (req_ready && !rsp_valid) ? i + 1 : 0;
    end
  endtask
  task automatic sel(input logic [47:0] u);
    send(5'b10100, 6'h18, u, 6'h00, 8'h00, 8'h00, 32'h0, 1'b0);
  endtask
endmodule

// File: bench/test_tag_block_command_handler.sv
// Purpose: self-checking bench for the command handler
// Assumes: memory is written before it is read
// Notes: registers over AHB-Lite, requests through the reader model
`timescale 1ns/1ps
`include "tbc_consts.vh"
module test_tag_block_command_handler;
  localparam logic [47:0] UID = `TBC_UID_RST;
  localparam logic [5:0] RD = `TBC_CMD_READ_MULTI, WR = `TBC_CMD_WRITE, LK = `TBC_CMD_LOCK;
  localparam logic [1:0] KU = `TBC_KIND_UID, KF = `TBC_KIND_FLAG, KW = `TBC_KIND_WORD;
  localparam logic [1:0] KE = `TBC_KIND_END;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  wire hreadyout, hresp, req_valid, req_ready, req_error, slot_pulse;
  wire rsp_valid, rsp_ready, rsp_dual;
  wire [31:0] hrdata, req_data;
  wire [4:0] req_flags;
  wire [5:0] req_cmd, req_mask_len, rsp_bits;
  wire [47:0] req_uid, req_mask, rsp_data;
  wire [7:0] req_block, req_count;
  wire [1:0] rsp_kind;
  int miscompares = 0, n_checks = 0;
  always #5 hclk = ~hclk;
  tbc_command_handler dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .req_valid(req_valid),
    .req_ready(req_ready), .req_flags(req_flags), .req_cmd(req_cmd), .req_uid(req_uid),
    .req_mask_len(req_mask_len), .req_mask(req_mask), .req_block(req_block),
    .req_count(req_count), .req_data(req_data), .req_error(req_error),
    .slot_pulse(slot_pulse), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_kind(rsp_kind), .rsp_data(rsp_data), .rsp_bits(rsp_bits), .rsp_dual(rsp_dual));
  tbc_reader rdr (.clk(hclk), .req_ready(req_ready), .req_valid(req_valid),
    .req_flags(req_flags), .req_cmd(req_cmd), .req_uid(req_uid),
    .req_mask_len(req_mask_len), .req_mask(req_mask), .req_block(req_block),
    .req_count(req_count), .req_data(req_data), .req_error(req_error),
    .slot_pulse(slot_pulse), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .rsp_kind(rsp_kind), .rsp_data(rsp_data), .rsp_bits(rsp_bits), .rsp_dual(rsp_dual));
  ////////////////////////////////////////
  task automatic chk(input logic [63:0] g, e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, d, e);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (!hreadyout) @(posedge hclk);
    chk(hresp, 0);
    if (!w) chk(hrdata, e);
  endtask
  task automatic fld(input logic [1:0] k, input logic [5:0] b, input logic [47:0] d);
    logic [56:0] f;
    f = rdr.q.size() ? rdr.q.pop_front() : 'x;
    if (k == KE) chk({f[56:55], f[0]}, {k, d[0]});
    else chk({f[56:48], f[47:0] & ((48'h1 << b) - 48'h1)}, {k, k == KU, b, d});
  endtask
  task automatic ok(input logic c);
    fld(KF, 6'd1, 48'h0);
    fld(KE, 6'd0, {47'h0, c});
  endtask
  task automatic er();
    fld(KF, 6'd4, 48'hF);
    fld(KE, 6'd0, 48'h1);
  endtask
  task automatic rdok(input logic [31:0] a);
    fld(KF, 6'd1, 48'h0);
    fld(KW, 6'd32, {16'h0, a});
    fld(KE, 6'd0, 48'h1);
  endtask
  task automatic rq(input logic [4:0] f, input logic [5:0] c, input logic [7:0] b, n,
    input logic [31:0] d);
    rdr.send(f, c, UID, 6'h00, b, n, d, 1'b0);
  endtask
  task automatic conclude();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    #500us;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(0, `TBC_OFF_UID_LO, 0, UID[31:0]);
    ahb(0, `TBC_OFF_UID_HI, 0, {16'h0, UID[47:32]});
    ahb(0, 32'h0000_0040, 0, 0);
    ahb(1, `TBC_OFF_CTRL, 32'h0000_0004, 0);
    ahb(0, `TBC_OFF_CTRL, 0, 32'h0000_0004);
    $display("test registers done");
    rq(5'b00100, WR, 8'h03, 8'h00, 32'hA5A5_0001); ok(1);
    rq(5'b00000, WR, 8'h04, 8'h00, 32'h5A5A_0002); ok(0);
    rdr.send(5'b10100, WR, UID, 0, 8'hFF, 0, 32'h0000_00FF, 0); ok(1);
    rdr.slow = 1;
    rq(5'b00100, RD, 8'h03, 8'h01, 0); fld(KF, 1, 0);
    fld(KW, 32, 48'hA5A5_0001); fld(KW, 32, 48'h5A5A_0002); fld(KE, 0, 1);
    rq(5'b00100, RD, 8'hFF, 8'h00, 0); rdok(32'h0000_00FF);
    rdr.slow = 0;
    rdr.send(5'b10110, RD, UID, 0, 8'h03, 0, 0, 0); fld(KU, 48, UID);
    rdok(32'hA5A5_0001);
    rdr.send(5'b00110, RD, UID, 0, 8'h04, 0, 0, 0); fld(KU, 48, UID);
    rdok(32'h5A5A_0002);
    rdr.send(5'b10110, RD, UID, 0, 8'h03, 0, 0, 1); chk(rdr.q.size(), 0);
    $display("test reads done");
    rq(5'b00100, LK, 8'h03, 8'h00, 0); ok(1);
    rq(5'b00100, WR, 8'h03, 8'h00, 32'h1111_1111); er();
    rq(5'b00100, RD, 8'h03, 8'h00, 0); rdok(32'hA5A5_0001);
    rq(5'b00100, LK, 8'h03, 8'h00, 0); er();
    rq(5'b00100, WR, 8'h40, 8'h00, 32'h1111_1111); er();
    rq(5'b00100, LK, 8'h20, 8'h00, 0); ok(1);
    rq(5'b00100, WR, 8'h18, 8'h00, 32'h1111_1111); er();
    rq(5'b00100, WR, 8'h36, 8'h00, 32'h1111_1111); er();
    ahb(1, `TBC_OFF_CTRL, 32'h0000_0001, 0);
    rq(5'b00100, LK, 8'h05, 8'h00, 0); er();
    ahb(1, `TBC_OFF_CTRL, 32'h0000_0003, 0);
    rq(5'b00100, LK, 8'h05, 8'h00, 0); ok(1);
    rq(5'b00100, LK, 8'hFE, 8'h00, 0); ok(1);
    rdr.send(5'b10100, WR, ~UID, 0, 8'h06, 0, 0, 0); chk(rdr.q.size(), 0);
    $display("test locks done");
    rdr.sel(UID); ok(1);
    rq(5'b01100, RD, 8'h04, 8'h00, 0); rdok(32'h5A5A_0002);
    ahb(1, `TBC_OFF_CTRL, 32'h0000_000B, 0);
    rq(5'b01100, RD, 8'h04, 8'h00, 0); chk(rdr.q.size(), 0);
    rdr.sel(~UID); chk(rdr.q.size(), 0);
    rq(5'b00100, RD, 8'h04, 8'h00, 0); chk(rdr.q.size(), 0);
    rdr.sel(~UID); chk(rdr.q.size(), 0);
    rq(5'b00100, RD, 8'h04, 8'h00, 0); chk(rdr.q.size(), 0);
    ahb(0, `TBC_OFF_COUNT, 0, 32'h0000_001B);
    ahb(0, `TBC_OFF_STATUS, 0, 32'h0000_0018);
    $display("test select done");
    conclude();
  end
endmodule
